//--- rtl/cips_pkg.sv
// Shared constants, timing and state type for the protection sequencer
package cips_pkg;

    // Clock rate in MHz, used to turn times into cycle counts
    localparam int CLK_MHZ = 125;

    // Widths of the long timers and of the current step counter
    localparam int TMR_W = 21;
    localparam int STEP_W = 4;

    // Soft-start step levels
    localparam logic [STEP_W-1:0] STEP_NONE = 4'h0;
    localparam logic [STEP_W-1:0] STEP_FIRST = 4'h1;
    localparam logic [STEP_W-1:0] NUM_STEPS = 4'h8;

    // Times in their own units, figures as specified
    localparam int POWER_GOOD_DEGLITCH_TIME_MS = 9;
    localparam int INPUT_OVERVOLTAGE_RECOVERY_TIME_MS = 9;
    localparam int BATTERY_TRIP_DEGLITCH_TIME_US = 180;
    localparam int SOFT_START_STEP_TIME_US = 625;
    localparam int OVERLOAD_CHECK_TIME_MS = 5;
    localparam int OVERLOAD_RETRY_TIME_MS = 9;
    localparam int US_PER_MS = 1000;

    // Whole microseconds give whole cycles at this rate, no rounding
    function automatic logic [TMR_W-1:0] us_to_cycles(input int us);
        return TMR_W'(us * CLK_MHZ);
    endfunction : us_to_cycles

    // Cycle counts derived from the times above
    localparam logic [TMR_W-1:0] PGOOD_CYCLES =
        us_to_cycles(POWER_GOOD_DEGLITCH_TIME_MS * US_PER_MS);
    localparam logic [TMR_W-1:0] OVREC_CYCLES =
        us_to_cycles(INPUT_OVERVOLTAGE_RECOVERY_TIME_MS * US_PER_MS);
    localparam logic [TMR_W-1:0] BAT_DGL_CYCLES =
        us_to_cycles(BATTERY_TRIP_DEGLITCH_TIME_US);
    localparam logic [TMR_W-1:0] STEP_CYCLES =
        us_to_cycles(SOFT_START_STEP_TIME_US);
    localparam logic [TMR_W-1:0] CHECK_CYCLES =
        us_to_cycles(OVERLOAD_CHECK_TIME_MS * US_PER_MS);
    localparam logic [TMR_W-1:0] RETRY_CYCLES =
        us_to_cycles(OVERLOAD_RETRY_TIME_MS * US_PER_MS);

    // Sequencer states
    typedef enum logic [3:0] {
        ST_OFF,
        ST_PGOOD,
        ST_START,
        ST_CHECK,
        ST_RUN,
        ST_STOP,
        ST_RETRY,
        ST_FAULT,
        ST_OVREC
    } cips_state_t;

endpackage : cips_pkg

//--- rtl/cips_tmr_if.sv
// Load and expiry signals between the sequencer and a countdown timer
`timescale 1ns/100ps
interface cips_tmr_if #(parameter int W = 21);
    logic load;
    logic [W-1:0] value;
    logic done;

    // Controller side loads, timer side reports
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface : cips_tmr_if

//--- rtl/cips_timer.sv
// Loadable countdown timer with a one-cycle expiry pulse
`timescale 1ns/100ps
module cips_timer #(
    parameter int W = 21
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Load and expiry
    cips_tmr_if.tmr t
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] one;

    // Expiry decodes the count alone, so a load may depend on it
    assign one = W'(1);
    assign cnt_nxt = t.load ? t.value :
                     (cnt_r != '0) ? cnt_r - one : cnt_r;
    assign t.done = (cnt_r == one);

    // Counter register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

endmodule : cips_timer

//--- rtl/cips_deglitch.sv
// Qualifies a level that must stay high for a set number of cycles
`timescale 1ns/100ps
module cips_deglitch #(
    parameter int W = 21,
    parameter logic [W-1:0] HOLD = 21'h057e4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw and qualified level
    input wire logic raw,
    output logic clean
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // Falls at once; the comparator already carries the hysteresis
    assign cnt_nxt = !raw ? '0 :
                     (cnt_r == HOLD) ? cnt_r : cnt_r + W'(1);
    assign clean = (cnt_r == HOLD);

    // Run-length counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

endmodule : cips_deglitch

//--- rtl/cips_sequencer.sv
// Charger input protection sequencer: switch, soft steps and fault pin
//
// Function
// - After lockout rise, reset, deglitch, check limits.
// - Soft-start raises current in 625 us steps.
// - Overload after eighth step starts clamped check.
// - Check expiry still clamped: soft-stop, fault, retry.
// - Retry expiry releases fault and restarts soft-start.
// - Clean start-up disables overload check, runs normally.
// - Below lockout: switch open, fault released.
// - Input overvoltage opens switch and drives fault at once.
// - Input overvoltage clear: wait recovery time, reclose.
// - Battery trip past deglitch: soft-stop and fault.
// - Battery back below hysteresis: soft-start again.
// - Thermal trip opens switch and drives fault.
// - Thermal clear below hysteresis recloses switch.
// - Enable high forces open; low starts up.
// - Floating enable reads as enabled.
// - Enable high keeps fault released.
// - Power-good deglitch is 9 ms.
// - Overvoltage recovery deglitch is 9 ms.
// - Battery trip deglitch is 180 us.
`timescale 1ns/100ps
module cips_sequencer #(
    parameter logic [cips_pkg::TMR_W-1:0] PGOOD_CYCLES_P =
        cips_pkg::PGOOD_CYCLES,
    parameter logic [cips_pkg::TMR_W-1:0] OVREC_CYCLES_P =
        cips_pkg::OVREC_CYCLES,
    parameter logic [cips_pkg::TMR_W-1:0] BAT_DGL_CYCLES_P =
        cips_pkg::BAT_DGL_CYCLES,
    parameter logic [cips_pkg::TMR_W-1:0] STEP_CYCLES_P =
        cips_pkg::STEP_CYCLES,
    parameter logic [cips_pkg::TMR_W-1:0] CHECK_CYCLES_P =
        cips_pkg::CHECK_CYCLES,
    parameter logic [cips_pkg::TMR_W-1:0] RETRY_CYCLES_P =
        cips_pkg::RETRY_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Comparator results
    input wire logic IN_ABOVE_LOCKOUT,
    input wire logic IN_OVERVOLTAGE,
    input wire logic BAT_OVERVOLTAGE,
    input wire logic THERMAL_TRIP,
    input wire logic OVERLOAD,
    // Host enable, active low, with pad float detect
    input wire logic ENABLE_N,
    input wire logic ENABLE_N_FLOAT,
    // Pass switch control
    output logic SWITCH_ON,
    output logic [cips_pkg::STEP_W-1:0] CURRENT_STEP,
    output logic CURRENT_CLAMP,
    // Open-drain fault indication, active low
    output logic FAULT_N_O,
    output logic FAULT_N_OE_N
);
    import cips_pkg::*;

    cips_state_t state_r;
    cips_state_t state_nxt;
    logic [STEP_W-1:0] step_r;
    logic [STEP_W-1:0] step_nxt;
    logic chk_en_r;
    logic chk_en_nxt;
    logic stop_ovl_r;
    logic stop_ovl_nxt;
    logic ovp_seen_r;
    logic ovp_seen_nxt;
    logic switch_r;
    logic switch_nxt;
    logic clamp_r;
    logic clamp_nxt;
    logic fault_r;
    logic fault_nxt;

    logic enabled;
    logic go_off;
    logic hard_fault;
    logic bat_fault;
    logic any_fault;
    logic step_tick;
    logic last_step;
    logic entering;
    logic main_load;
    logic step_load;
    logic ovl_stopping;

    cips_tmr_if #(.W(TMR_W)) main_tmr ();
    cips_tmr_if #(.W(TMR_W)) step_tmr ();

    // Long intervals: power-good, check, retry and recovery
    cips_timer #(
        .W(TMR_W)
    ) u_main_timer (
        .clk(CLK),
        .rst(RST),
        .t(main_tmr.tmr)
    );

    // Hold time of one soft-start or soft-stop step
    cips_timer #(
        .W(TMR_W)
    ) u_step_timer (
        .clk(CLK),
        .rst(RST),
        .t(step_tmr.tmr)
    );

    // Battery trip must persist before it counts
    cips_deglitch #(
        .W(TMR_W),
        .HOLD(BAT_DGL_CYCLES_P)
    ) u_bat_deglitch (
        .clk(CLK),
        .rst(RST),
        .raw(BAT_OVERVOLTAGE),
        .clean(bat_fault)
    );

    // Enable decode; an undriven pin behaves as pulled low
    assign enabled = !(ENABLE_N && !ENABLE_N_FLOAT);
    assign go_off = !IN_ABOVE_LOCKOUT || !enabled;

    // Faults that open the switch at once, without stepping down
    assign hard_fault = IN_OVERVOLTAGE || THERMAL_TRIP;
    assign any_fault = hard_fault || bat_fault;

    // Step bookkeeping
    assign step_tick = step_tmr.done;
    assign last_step = (step_r == NUM_STEPS);
    assign entering = (state_nxt != state_r);

    // Next state; lockout and enable win over everything
    always_comb
    begin
        state_nxt = state_r;
        stop_ovl_nxt = stop_ovl_r;
        chk_en_nxt = chk_en_r;
        if (go_off)
        begin
            state_nxt = ST_OFF;
        end
        else
        begin
            unique case (state_r)
                ST_OFF:
                begin
                    // Every start from off goes through the full power-good wait
                    state_nxt = ST_PGOOD;
                    chk_en_nxt = 1'b1;
                end
                ST_PGOOD:
                begin
                    // Limits only judged once the input has settled
                    if (main_tmr.done)
                        state_nxt = any_fault ? ST_FAULT : ST_START;
                end
                ST_START:
                begin
                    // Overload is judged only once the last step has run
                    if (hard_fault)
                        state_nxt = ST_FAULT;
                    else if (bat_fault)
                    begin
                        state_nxt = ST_STOP;
                        stop_ovl_nxt = 1'b0;
                    end
                    else if (step_tick && last_step)
                    begin
                        if (OVERLOAD && chk_en_r)
                            state_nxt = ST_CHECK;
                        else
                        begin
                            state_nxt = ST_RUN;
                            chk_en_nxt = 1'b0;
                        end
                    end
                end
                ST_CHECK:
                begin
                    // Current back under the limit ends the check early
                    if (hard_fault)
                        state_nxt = ST_FAULT;
                    else if (bat_fault)
                    begin
                        state_nxt = ST_STOP;
                        stop_ovl_nxt = 1'b0;
                    end
                    else if (!OVERLOAD)
                    begin
                        state_nxt = ST_RUN;
                        chk_en_nxt = 1'b0;
                    end
                    else if (main_tmr.done)
                    begin
                        state_nxt = ST_STOP;
                        stop_ovl_nxt = 1'b1;
                    end
                end
                ST_RUN:
                begin
                    // Overload here is left to the analogue limit
                    if (hard_fault)
                        state_nxt = ST_FAULT;
                    else if (bat_fault)
                    begin
                        state_nxt = ST_STOP;
                        stop_ovl_nxt = 1'b0;
                    end
                end
                ST_STOP:
                begin
                    // Hard faults skip the remaining steps
                    if (hard_fault)
                        state_nxt = ST_FAULT;
                    else if (step_tick && step_r <= STEP_FIRST)
                        state_nxt = stop_ovl_r ? ST_RETRY : ST_FAULT;
                end
                ST_RETRY:
                begin
                    // A battery trip here must not reclose the switch
                    if (any_fault)
                        state_nxt = ST_FAULT;
                    else if (main_tmr.done)
                        state_nxt = ST_START;
                end
                ST_FAULT:
                begin
                    // Overvoltage exit waits out the recovery time
                    if (!any_fault)
                        state_nxt = ovp_seen_r ? ST_OVREC : ST_START;
                end
                ST_OVREC:
                begin
                    // Any new fault sends it back to the fault state
                    if (any_fault)
                        state_nxt = ST_FAULT;
                    else if (main_tmr.done)
                        state_nxt = ST_START;
                end
            endcase
        end
    end

    // Remember an overvoltage for the recovery wait; fresh per fault
    assign ovp_seen_nxt = (state_nxt == ST_FAULT) &&
                          (ovp_seen_r || IN_OVERVOLTAGE);

    // Long timer loads on entry to each waiting state
    // Each wait reloads on entry, so an old expiry cannot leak
    assign main_load = entering && (state_nxt == ST_PGOOD ||
                       state_nxt == ST_CHECK || state_nxt == ST_RETRY ||
                       state_nxt == ST_OVREC);
    assign main_tmr.load = main_load;
    assign main_tmr.value =
        (state_nxt == ST_PGOOD) ? PGOOD_CYCLES_P :
        (state_nxt == ST_CHECK) ? CHECK_CYCLES_P :
        (state_nxt == ST_RETRY) ? RETRY_CYCLES_P :
        OVREC_CYCLES_P;

    // Step timer reloads on entry and on each step while stepping
    // A tick that leaves the state does not reload; the timer idles
    assign step_load = (entering && state_nxt == ST_START) ||
                       (state_nxt == ST_STOP && state_r != ST_STOP) ||
                       (step_tick && state_nxt == state_r &&
                        (state_r == ST_START || state_r == ST_STOP));
    assign step_tmr.load = step_load;
    assign step_tmr.value = STEP_CYCLES_P;

    // Permitted current step: up in start, down in stop, held in check and run, else none
    assign step_nxt =
        (entering && state_nxt == ST_START) ? STEP_FIRST :
        (state_nxt == ST_START && step_tick && !last_step) ?
            step_r + STEP_FIRST :
        (state_nxt == ST_STOP && step_tick && step_r != STEP_NONE) ?
            step_r - STEP_FIRST :
        (state_nxt == ST_START || state_nxt == ST_CHECK ||
         state_nxt == ST_RUN || state_nxt == ST_STOP) ? step_r :
        STEP_NONE;

    // Switch closed only while conducting states hold
    assign switch_nxt = (state_nxt == ST_START) ||
                        (state_nxt == ST_CHECK) ||
                        (state_nxt == ST_RUN) ||
                        (state_nxt == ST_STOP);
    assign clamp_nxt = (state_nxt == ST_CHECK);

    // Fault pin; an overload stop counts as a fault until retry ends
    // Lockout or disable releases the pin whatever the fault
    assign ovl_stopping = stop_ovl_nxt &&
                          (state_nxt == ST_STOP || state_nxt == ST_RETRY);
    assign fault_nxt = enabled && IN_ABOVE_LOCKOUT &&
                       (any_fault || ovl_stopping);

    // State and mode registers
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= ST_OFF;
            stop_ovl_r <= 1'b0;
            chk_en_r <= 1'b0;
            ovp_seen_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            stop_ovl_r <= stop_ovl_nxt;
            chk_en_r <= chk_en_nxt;
            ovp_seen_r <= ovp_seen_nxt;
        end
    end

    // Output registers; switch and fault change on the same edge
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            step_r <= STEP_NONE;
            switch_r <= 1'b0;
            clamp_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            step_r <= step_nxt;
            switch_r <= switch_nxt;
            clamp_r <= clamp_nxt;
            fault_r <= fault_nxt;
        end
    end

    // Port drive; the open-drain pin only ever pulls low
    assign SWITCH_ON = switch_r;
    assign CURRENT_STEP = step_r;
    assign CURRENT_CLAMP = clamp_r;
    assign FAULT_N_O = 1'b0;
    assign FAULT_N_OE_N = !fault_r;

endmodule : cips_sequencer

//--- tb/cips_host_model.sv
// Host processor pins: enable drive and fault read-back
`timescale 1ns/100ps
module cips_host_model (
    // Bench controls of the host pin
    input wire logic drive_en,
    input wire logic en_level,
    // Device side pins
    input wire logic fault_n_o,
    input wire logic fault_n_oe_n,
    output logic enable_n,
    output logic enable_n_float,
    output logic fault_line
);
    // Released enable falls to the device pull-down
    assign enable_n = drive_en ? en_level : 1'b0;
    assign enable_n_float = !drive_en;
    // Fault line rests on the board pull-up unless sunk
    assign fault_line = (fault_n_oe_n == 1'b0) ? fault_n_o : 1'b1;
endmodule : cips_host_model

//--- tb/cips_sequencer_chk.sv
// Port checker for the protection sequencer
`timescale 1ns/100ps
module cips_chk
    import cips_pkg::*;
#(
    parameter logic [cips_pkg::TMR_W-1:0] PGOOD_CYCLES_P =
        cips_pkg::PGOOD_CYCLES,
    parameter logic [cips_pkg::TMR_W-1:0] STEP_CYCLES_P =
        cips_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Comparators and enable
    input wire logic IN_ABOVE_LOCKOUT,
    input wire logic IN_OVERVOLTAGE,
    input wire logic BAT_OVERVOLTAGE,
    input wire logic THERMAL_TRIP,
    input wire logic OVERLOAD,
    input wire logic ENABLE_N,
    input wire logic ENABLE_N_FLOAT,
    // Switch and fault pin
    input wire logic SWITCH_ON,
    input wire logic [cips_pkg::STEP_W-1:0] CURRENT_STEP,
    input wire logic CURRENT_CLAMP,
    input wire logic FAULT_N_O,
    input wire logic FAULT_N_OE_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic en;
    logic chg;
    logic up;
    logic dir_r;
    logic [STEP_W-1:0] prev_r;
    logic [TMR_W-1:0] held_r;
    logic [TMR_W-1:0] on_r;
    assign en = !ENABLE_N || ENABLE_N_FLOAT;
    assign chg = CURRENT_STEP != prev_r;
    assign up = CURRENT_STEP > prev_r;
    // Step hold length, direction, and powered run length
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            prev_r <= STEP_NONE;
            dir_r <= 1'b1;
            held_r <= '0;
            on_r <= '0;
        end
        else
        begin
            prev_r <= CURRENT_STEP;
            if (chg)
                dir_r <= up;
            held_r <= chg ? TMR_W'(1) : held_r + 1'b1;
            if (!(IN_ABOVE_LOCKOUT && en))
                on_r <= '0;
            else if (on_r != '1)
                on_r <= on_r + 1'b1;
        end
    end

    AST_LOCKOUT_OFF: assert property (!IN_ABOVE_LOCKOUT |=>
        !SWITCH_ON && FAULT_N_OE_N && CURRENT_STEP == STEP_NONE)
        else $error("switch or fault pin active below lockout");
    AST_DISABLED: assert property (!en |=>
        !SWITCH_ON && FAULT_N_OE_N)
        else $error("disabled device not fully off");
    AST_OV_OPEN: assert property (
        IN_ABOVE_LOCKOUT && en && IN_OVERVOLTAGE |=> !SWITCH_ON)
        else $error("switch stayed on at input overvoltage");
    AST_THERM_OPEN: assert property (
        IN_ABOVE_LOCKOUT && en && THERMAL_TRIP |=> !SWITCH_ON)
        else $error("switch stayed on at thermal trip");
    AST_FIRST_STEP: assert property (
        $rose(SWITCH_ON) |-> CURRENT_STEP == STEP_FIRST)
        else $error("switch closed at wrong step");
    AST_PGOOD_WAIT: assert property (
        $rose(SWITCH_ON) |-> on_r >= PGOOD_CYCLES_P)
        else $error("switch closed before power-good wait");
    AST_STEP_ADJ: assert property (
        chg && CURRENT_STEP != 4'h0 && prev_r != 4'h0 |->
        CURRENT_STEP == prev_r + 4'h1 || CURRENT_STEP + 4'h1 == prev_r)
        else $error("step skipped a level");
    AST_STEP_HOLD: assert property (
        chg && CURRENT_STEP != 4'h0 && prev_r != 4'h0 && up == dir_r
        |-> held_r == STEP_CYCLES_P)
        else $error("step held for wrong time");
    AST_CLAMP_FULL: assert property (
        CURRENT_CLAMP |-> SWITCH_ON && CURRENT_STEP == NUM_STEPS)
        else $error("clamp outside full step");
endmodule : cips_chk

bind cips_sequencer cips_chk #(
    .PGOOD_CYCLES_P(PGOOD_CYCLES_P),
    .STEP_CYCLES_P(STEP_CYCLES_P)
) u_chk (
    .CLK(CLK), .RST(RST), .IN_ABOVE_LOCKOUT(IN_ABOVE_LOCKOUT),
    .IN_OVERVOLTAGE(IN_OVERVOLTAGE), .BAT_OVERVOLTAGE(BAT_OVERVOLTAGE),
    .THERMAL_TRIP(THERMAL_TRIP), .OVERLOAD(OVERLOAD),
    .ENABLE_N(ENABLE_N), .ENABLE_N_FLOAT(ENABLE_N_FLOAT),
    .SWITCH_ON(SWITCH_ON), .CURRENT_STEP(CURRENT_STEP),
    .CURRENT_CLAMP(CURRENT_CLAMP), .FAULT_N_O(FAULT_N_O),
    .FAULT_N_OE_N(FAULT_N_OE_N)
);

//--- tb/tb.sv
// Self-checking bench for the protection sequencer
`timescale 1ns/100ps
module tb;
    import cips_pkg::*;
    // Shortened timer lengths, all expectations derive from these
    localparam int PG = 40;
    localparam int OR = 50;
    localparam int CK = 60;
    localparam int RT = 70;
    localparam int SP = 10;
    localparam int BD = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lock = 1'b1;
    logic ov = 1'b0;
    logic bat = 1'b0;
    logic hot = 1'b0;
    logic load = 1'b0;
    logic drv = 1'b1;
    logic lvl = 1'b0;
    logic en_n;
    logic en_fl;
    logic fault;
    logic sw;
    logic clamp;
    logic fo;
    logic foe_n;
    logic [STEP_W-1:0] step;
    int err_count = 0;
    int checks = 0;
    int n;

    cips_sequencer #(
        .PGOOD_CYCLES_P(TMR_W'(PG)), .OVREC_CYCLES_P(TMR_W'(OR)),
        .BAT_DGL_CYCLES_P(TMR_W'(BD)), .STEP_CYCLES_P(TMR_W'(SP)),
        .CHECK_CYCLES_P(TMR_W'(CK)), .RETRY_CYCLES_P(TMR_W'(RT))
    ) DUT (
        .CLK(clk), .RST(rst), .IN_ABOVE_LOCKOUT(lock),
        .IN_OVERVOLTAGE(ov), .BAT_OVERVOLTAGE(bat), .THERMAL_TRIP(hot),
        .OVERLOAD(load), .ENABLE_N(en_n), .ENABLE_N_FLOAT(en_fl),
        .SWITCH_ON(sw), .CURRENT_STEP(step), .CURRENT_CLAMP(clamp),
        .FAULT_N_O(fo), .FAULT_N_OE_N(foe_n)
    );
    cips_host_model u_host (
        .drive_en(drv), .en_level(lvl), .fault_n_o(fo),
        .fault_n_oe_n(foe_n), .enable_n(en_n), .enable_n_float(en_fl),
        .fault_line(fault)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Passes when v lies in lo..hi, else reports the nearest bound
    task automatic check_rng(input int v, input int lo, input int hi);
        check(v, (v < lo) ? lo : (v > hi) ? hi : v);
    endtask : check_rng

    function automatic logic hit(input int sel);
        case (sel)
            0: return sw === 1'b1;
            1: return sw === 1'b0;
            2: return fault === 1'b0;
            3: return fault === 1'b1;
            default: return clamp === 1'b1;
        endcase
    endfunction : hit

    // Edges counted until the condition shows, bounded by lim
    task automatic wait_for(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (!hit(sel) && cnt < lim)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : wait_for

    task automatic settle();
        repeat (8 * SP + 5) @(posedge clk);
        #1;
    endtask : settle

    task automatic t_startup();
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        wait_for(0, PG + 10, n);
        check_rng(n, PG, PG + 4);
        check(step, STEP_FIRST);
        settle();
        check(step, NUM_STEPS);
        @(posedge clk);
        load <= 1'b1;
        repeat (2 * CK) @(posedge clk);
        #1;
        check({clamp, fault, sw}, 3'h3);
        @(posedge clk);
        load <= 1'b0;
    endtask : t_startup

    task automatic t_overload();
        @(posedge clk);
        lvl <= 1'b1;
        #1;
        wait_for(1, 3, n);
        check(n, 1);
        @(posedge clk);
        lvl <= 1'b0;
        load <= 1'b1;
        #1;
        wait_for(0, PG + 10, n);
        wait_for(4, 8 * SP + 10, n);
        check_rng(n, 8 * SP - 1, 8 * SP + 2);
        check(step, NUM_STEPS);
        wait_for(2, CK + 10, n);
        check_rng(n, CK - 1, CK + 2);
        check(sw, 1'b1);
        wait_for(1, 8 * SP + 10, n);
        check_rng(n, 8 * SP - 2, 8 * SP + 2);
        wait_for(3, RT + 10, n);
        check_rng(n, RT - 1, RT + 2);
        wait_for(0, 3, n);
        check(step, STEP_FIRST);
        wait_for(4, 8 * SP + 10, n);
        check_rng(n, 8 * SP - 1, 8 * SP + 2);
        @(posedge clk);
        load <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({clamp, fault, sw}, 3'h3);
    endtask : t_overload

    task automatic t_ovp();
        @(posedge clk);
        ov <= 1'b1;
        #1;
        wait_for(1, 3, n);
        check(n, 1);
        check(fault, 1'b0);
        @(posedge clk);
        lvl <= 1'b1;
        #1;
        wait_for(3, 3, n);
        check(n, 1);
        @(posedge clk);
        lvl <= 1'b0;
        #1;
        wait_for(2, 3, n);
        check(n, 1);
        repeat (PG + 4) @(posedge clk);
        #1;
        check({sw, fault}, 2'h0);
        @(posedge clk);
        ov <= 1'b0;
        #1;
        wait_for(0, OR + 10, n);
        check_rng(n, OR, OR + 3);
        check(fault, 1'b1);
        settle();
    endtask : t_ovp

    task automatic t_bat();
        @(posedge clk);
        bat <= 1'b1;
        repeat (BD - 5) @(posedge clk);
        bat <= 1'b0;
        #1;
        wait_for(2, 10, n);
        check(n, 10);
        @(posedge clk);
        bat <= 1'b1;
        #1;
        wait_for(2, BD + 10, n);
        check_rng(n, BD, BD + 4);
        check({sw, step}, {1'b1, NUM_STEPS});
        wait_for(1, 8 * SP + 10, n);
        check_rng(n, 8 * SP - 2, 8 * SP + 2);
        @(posedge clk);
        bat <= 1'b0;
        #1;
        wait_for(0, 4, n);
        check_rng(n, 1, 3);
        check(step, STEP_FIRST);
        settle();
    endtask : t_bat

    task automatic t_therm();
        @(posedge clk);
        hot <= 1'b1;
        #1;
        wait_for(1, 3, n);
        check({n[3:0], fault}, 5'h2);
        repeat (20) @(posedge clk);
        #1;
        check(sw, 1'b0);
        @(posedge clk);
        hot <= 1'b0;
        #1;
        wait_for(0, 4, n);
        check_rng(n, 1, 3);
        settle();
    endtask : t_therm

    task automatic t_lock();
        @(posedge clk);
        ov <= 1'b1;
        #1;
        wait_for(2, 3, n);
        @(posedge clk);
        lock <= 1'b0;
        #1;
        wait_for(3, 3, n);
        check({n[3:0], sw}, 5'h2);
        @(posedge clk);
        ov <= 1'b0;
        lock <= 1'b1;
        #1;
        wait_for(0, PG + 10, n);
        check_rng(n, PG, PG + 4);
        settle();
    endtask : t_lock

    task automatic t_float();
        @(posedge clk);
        lvl <= 1'b1;
        drv <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        check({sw, fault}, 2'h3);
        @(posedge clk);
        drv <= 1'b1;
        #1;
        wait_for(1, 3, n);
        check(n, 1);
    endtask : t_float

    task automatic report_and_stop();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        t_startup();
        t_overload();
        t_ovp();
        t_bat();
        t_therm();
        t_lock();
        t_float();
        report_and_stop();
    end

    // Watchdog well beyond the roughly 1400 cycles the tests take
    initial
    begin
        #(8 * 20000);
        err_count++;
        report_and_stop();
    end
endmodule : tb
